// file: verilog/rxdst_status_tracker.sv
// Receive channel status tracking for the descriptor DMA engine
//
// Operation
// R1 - Channel busy stays set while queues hold data or work remains; resets zero.
// R2 - Chain busy stays set while descriptors remain in the active chain.
// R3 - Chain busy may clear with write-backs outstanding; it proves no flush.
// R4 - Stream end-of-packet sets the end-of-packet bit of current descriptor.
// R5 - Stream start-of-packet sets the start-of-packet bit of current descriptor.
// R6 - Transfer until length reaches zero or end-of-packet, then set completed.
// R7 - Stop-on-end set halts the channel once that descriptor completes.
// R8 - Stop and interrupt controls load from each descriptor as it starts.
// R9 - Interrupt-on-end with feature enable raises an event at every completion.
// R10 - Status error bit is a direct copy of the error-pending flag.
// R11 - Software should not write the status register in normal operation.
// R12 - Software should set stop-on-end only on an end-of-packet descriptor.
// R13 - Writing one to the error-pending flag clears it.
// R14 - Status is 32 bits, bit 0 most significant; bits 0 to 23 read zero.
`timescale 1ns/1ps
module rxdst_status_tracker #(
    parameter int LEN_WIDTH = rxdst_pkg::DESC_LEN_WIDTH
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Descriptor hand-off from the fetch path
    input wire logic descValid,
    input wire rxdst_pkg::rxdst_desc_type descIn,
    output logic descReady,
    // Descriptor completion toward the write-back path
    output logic descDone,
    // Framed receive stream
    input wire rxdst_pkg::rxdst_beat_type beatIn,
    output logic streamReady,
    // Channel conditions
    input wire logic chainPending,
    input wire logic queuesEmpty,
    input wire logic rxErrorEvent,
    input wire logic descriptor_completion_irq_enable,
    input wire logic channelRestart,
    output logic channelHalted,
    output logic irqEvent,
    // Control register bus access
    input wire logic statusWrite,
    input wire logic intrWrite,
    input wire logic [0:rxdst_pkg::STATUS_WIDTH-1] writeData,
    output logic [0:rxdst_pkg::STATUS_WIDTH-1] rx_channel_status,
    output logic rx_error_pending
);
    rxdst_pkg::rxdst_state_type st;
    rxdst_pkg::rxdst_state_type next_st;
    logic [LEN_WIDTH-1:0] remaining;
    logic descLoad;
    logic beatTaken;
    logic lastByLength;
    logic completeNow;
    logic errAck;

    initial begin
        if (LEN_WIDTH != rxdst_pkg::DESC_LEN_WIDTH) begin
            $error("length width must match the descriptor length field");
        end
    end

    function automatic logic phaseIs(input rxdst_pkg::rxdst_phase_type ph,
                                     input rxdst_pkg::rxdst_phase_type want);
        phaseIs = (ph == want);
    endfunction : phaseIs

    // A new descriptor is only taken while idle, never while halted
    assign descLoad = descValid && phaseIs(st.phase, rxdst_pkg::PH_IDLE);
    assign descReady = phaseIs(st.phase, rxdst_pkg::PH_IDLE);
    assign streamReady = phaseIs(st.phase, rxdst_pkg::PH_ACTIVE) && (remaining != '0);
    assign beatTaken = beatIn.valid && streamReady;
    assign lastByLength = beatTaken && (remaining == rxdst_pkg::LEN_ONE);
    // A zero-length descriptor completes without taking any beat
    assign completeNow = phaseIs(st.phase, rxdst_pkg::PH_ACTIVE)
                         && (lastByLength || (beatTaken && beatIn.endOfPacketMarker)
                             || (remaining == rxdst_pkg::LEN_ZERO)); // R6
    assign errAck = intrWrite && writeData[rxdst_pkg::INTR_BIT_ERR];

    rxdst_len_counter #(
        .WIDTH(LEN_WIDTH)
    ) u_len (
        .core_clk(core_clk),
        .reset(reset),
        .load(descLoad),
        .loadValue(descIn.length),
        .decrement(beatTaken),
        .remaining(remaining)
    );

    always_comb begin
        next_st = st;
        next_st.irqEvent = 1'b0;
        next_st.descDone = 1'b0;
        // Debug writes land first so hardware events below win over them
        if (statusWrite) begin
            next_st.eop = writeData[rxdst_pkg::BIT_EOP];
            next_st.sop = writeData[rxdst_pkg::BIT_SOP];
            next_st.done = writeData[rxdst_pkg::BIT_DONE];
            next_st.stopOnEnd = writeData[rxdst_pkg::BIT_STOP];
            next_st.irqOnEnd = writeData[rxdst_pkg::BIT_IRQ];
        end
        unique case (st.phase)
            rxdst_pkg::PH_IDLE: begin
                if (descLoad) begin
                    next_st.phase = rxdst_pkg::PH_ACTIVE;
                    next_st.stopOnEnd = descIn.stopOnEnd; // R8
                    next_st.irqOnEnd = descIn.irqOnEnd; // R8
                    next_st.eop = 1'b0;
                    next_st.sop = 1'b0;
                    next_st.done = 1'b0;
                end
            end
            rxdst_pkg::PH_ACTIVE: begin
                if (beatTaken && beatIn.startOfPacketMarker) begin
                    next_st.sop = 1'b1; // R5
                end
                if (beatTaken && beatIn.endOfPacketMarker) begin
                    next_st.eop = 1'b1; // R4
                end
                if (completeNow) begin
                    next_st.done = 1'b1; // R6
                    next_st.descDone = 1'b1;
                    next_st.irqEvent = st.irqOnEnd && descriptor_completion_irq_enable; // R9
                    if (st.stopOnEnd) begin
                        next_st.phase = rxdst_pkg::PH_HALTED; // R7
                    end else begin
                        next_st.phase = rxdst_pkg::PH_IDLE;
                    end
                end
            end
            rxdst_pkg::PH_HALTED: begin
                if (channelRestart) begin
                    next_st.phase = rxdst_pkg::PH_IDLE;
                end
            end
            default: begin
                next_st.phase = rxdst_pkg::PH_IDLE;
            end
        endcase
        // Busy covers queued data and any descriptor in hand
        next_st.chanBusy = !queuesEmpty || chainPending
                           || !phaseIs(next_st.phase, rxdst_pkg::PH_IDLE); // R1
        // Chain busy ignores write-backs, so it may drop before the flush
        next_st.chainBusy = chainPending
                            || phaseIs(next_st.phase, rxdst_pkg::PH_ACTIVE); // R2 R3
        // Set wins over the acknowledge in the same cycle
        if (rxErrorEvent) begin
            next_st.rxErrorPending = 1'b1;
        end else if (errAck) begin
            next_st.rxErrorPending = 1'b0; // R13
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st <= '{phase: rxdst_pkg::PH_IDLE, default: 1'b0}; // R1
        end else begin
            st <= next_st;
        end
    end

    always_comb begin
        rx_channel_status = rxdst_pkg::STATUS_RESET;
        rx_channel_status[0:rxdst_pkg::RESERVED_LAST] = rxdst_pkg::RESERVED_VALUE; // R14
        rx_channel_status[rxdst_pkg::BIT_CHAN_BUSY] = st.chanBusy; // R1
        rx_channel_status[rxdst_pkg::BIT_CHAIN_BUSY] = st.chainBusy; // R2
        rx_channel_status[rxdst_pkg::BIT_EOP] = st.eop;
        rx_channel_status[rxdst_pkg::BIT_SOP] = st.sop;
        rx_channel_status[rxdst_pkg::BIT_DONE] = st.done;
        rx_channel_status[rxdst_pkg::BIT_STOP] = st.stopOnEnd;
        rx_channel_status[rxdst_pkg::BIT_IRQ] = st.irqOnEnd;
        rx_channel_status[rxdst_pkg::BIT_ERR] = st.rxErrorPending; // R10
    end

    assign rx_error_pending = st.rxErrorPending;
    assign channelHalted = phaseIs(st.phase, rxdst_pkg::PH_HALTED);
    assign irqEvent = st.irqEvent;
    assign descDone = st.descDone;

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence seqStart;
        descLoad;
    endsequence

    sequence seqStopDone;
        completeNow && st.stopOnEnd && !statusWrite;
    endsequence

    sequence seqIrqDone;
        completeNow && st.irqOnEnd && descriptor_completion_irq_enable;
    endsequence

    chk_busy_work: assert property ( // R1
        (!queuesEmpty || descLoad) |=> rx_channel_status[rxdst_pkg::BIT_CHAN_BUSY])
        else $error("channel busy low while work is present");

    chk_busy_clear: assert property ( // R1
        (queuesEmpty && !chainPending && phaseIs(st.phase, rxdst_pkg::PH_IDLE) && !descLoad)
        |=> !rx_channel_status[rxdst_pkg::BIT_CHAN_BUSY])
        else $error("channel busy stuck with no work");

    chk_chain_active: assert property ( // R2
        (chainPending || (phaseIs(st.phase, rxdst_pkg::PH_ACTIVE) && !completeNow))
        |=> rx_channel_status[rxdst_pkg::BIT_CHAIN_BUSY])
        else $error("chain busy low while descriptors remain");

    chk_eop_mark: assert property ( // R4
        (beatTaken && beatIn.endOfPacketMarker) |=> rx_channel_status[rxdst_pkg::BIT_EOP]
        ##1 (rx_channel_status[rxdst_pkg::BIT_EOP] || $past(descLoad) || $past(statusWrite)))
        else $error("end-of-packet bit not set");

    chk_sop_mark: assert property ( // R5
        (beatTaken && beatIn.startOfPacketMarker) |=> rx_channel_status[rxdst_pkg::BIT_SOP])
        else $error("start-of-packet bit not set");

    chk_done_set: assert property ( // R6
        completeNow |=> rx_channel_status[rxdst_pkg::BIT_DONE] && descDone
        && !phaseIs(st.phase, rxdst_pkg::PH_ACTIVE))
        else $error("completion not recorded");

    chk_len_end: assert property ( // R6
        (phaseIs(st.phase, rxdst_pkg::PH_ACTIVE) && remaining == rxdst_pkg::LEN_ZERO)
        |-> completeNow && !streamReady)
        else $error("descriptor runs past its length");

    chk_stop_halt: assert property ( // R7
        seqStopDone |=> channelHalted[*2] or (channelHalted ##1 channelRestart))
        else $error("channel did not halt on stop-on-end");

    chk_load_ctrl: assert property ( // R8
        seqStart |=> (rx_channel_status[rxdst_pkg::BIT_STOP] == $past(descIn.stopOnEnd))
        && (rx_channel_status[rxdst_pkg::BIT_IRQ] == $past(descIn.irqOnEnd))
        && !rx_channel_status[rxdst_pkg::BIT_DONE])
        else $error("descriptor controls not loaded");

    chk_irq_event: assert property ( // R9
        seqIrqDone |=> irqEvent ##1 !irqEvent)
        else $error("interrupt event missing or long");

    chk_irq_cause: assert property ( // R9
        irqEvent |-> $past(completeNow) && $past(descriptor_completion_irq_enable))
        else $error("interrupt event without a cause");

    chk_err_copy: assert property ( // R10
        rxErrorEvent |=> rx_channel_status[rxdst_pkg::BIT_ERR] && rx_error_pending)
        else $error("error bit does not follow the pending flag");

    chk_err_ack: assert property ( // R13
        (errAck && !rxErrorEvent) |=> !rx_channel_status[rxdst_pkg::BIT_ERR])
        else $error("error flag not cleared by acknowledge");

    chk_reserved_zero: assert property ( // R14
        rx_channel_status[0:rxdst_pkg::RESERVED_LAST] == rxdst_pkg::RESERVED_VALUE)
        else $error("reserved status bits not zero");
endmodule : rxdst_status_tracker

// file: common/rxdst_pkg.sv
// Shared constants and types for the receive status tracker
package rxdst_pkg;
    // Status register geometry, bit 0 is the most significant bit
    localparam int STATUS_WIDTH = 32;
    localparam int BIT_CHAN_BUSY = 31;
    localparam int BIT_CHAIN_BUSY = 30;
    localparam int BIT_EOP = 29;
    localparam int BIT_SOP = 28;
    localparam int BIT_DONE = 27;
    localparam int BIT_STOP = 26;
    localparam int BIT_IRQ = 25;
    localparam int BIT_ERR = 24;
    localparam int RESERVED_LAST = 23;
    localparam logic [0:STATUS_WIDTH-1] STATUS_RESET = 32'h0000_0000;
    localparam logic [0:RESERVED_LAST] RESERVED_VALUE = 24'h00_0000;

    // Interrupt register error-pending flag position
    localparam int INTR_BIT_ERR = 29;

    // Descriptor length counter width
    localparam int DESC_LEN_WIDTH = 16;
    localparam logic [DESC_LEN_WIDTH-1:0] LEN_ZERO = 16'h0000;
    localparam logic [DESC_LEN_WIDTH-1:0] LEN_ONE = 16'h0001;

    typedef enum logic [2:0] {
        PH_IDLE = 3'b001,
        PH_ACTIVE = 3'b010,
        PH_HALTED = 3'b100
    } rxdst_phase_type;

    // One beat of the framed receive stream
    typedef struct packed {
        logic valid;
        logic startOfPacketMarker;
        logic endOfPacketMarker;
    } rxdst_beat_type;

    // Controls carried in a descriptor's status field
    typedef struct packed {
        logic stopOnEnd;
        logic irqOnEnd;
        logic [DESC_LEN_WIDTH-1:0] length;
    } rxdst_desc_type;

    // State of the tracker apart from the remaining-length count
    typedef struct packed {
        rxdst_phase_type phase;
        logic chanBusy;
        logic chainBusy;
        logic eop;
        logic sop;
        logic done;
        logic stopOnEnd;
        logic irqOnEnd;
        logic rxErrorPending;
        logic irqEvent;
        logic descDone;
    } rxdst_state_type;
endpackage : rxdst_pkg

// file: verilog/rxdst_len_counter.sv
// Remaining-length counter for the current descriptor
`timescale 1ns/1ps
module rxdst_len_counter #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Control
    input wire logic load,
    input wire logic [WIDTH-1:0] loadValue,
    input wire logic decrement,
    // Count
    output logic [WIDTH-1:0] remaining
);
    typedef struct packed {
        logic [WIDTH-1:0] count;
    } rxdst_cnt_type;

    rxdst_cnt_type st;
    rxdst_cnt_type next_st;

    initial begin
        if (WIDTH < 1) begin
            $error("length counter needs at least one bit");
        end
    end

    always_comb begin
        next_st = st;
        if (load) begin
            next_st.count = loadValue;
        end else if (decrement && (st.count != '0)) begin
            // Saturates at zero so a stray beat cannot wrap the count
            next_st.count = st.count - WIDTH'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign remaining = st.count;
endmodule : rxdst_len_counter

// file: bench/rxdst_stream_src.sv
// Framed receive stream source standing in for the far-side logic
`timescale 1ns/1ps
module rxdst_stream_src (
    // Clock
    input wire logic core_clk,
    // Stream
    input wire logic streamReady,
    output rxdst_pkg::rxdst_beat_type beatIn,
    // Status
    output logic timedOut
);
    initial begin
        beatIn = '0;
        timedOut = 1'b0;
    end
    // Beat is held until taken; released markers show the inverse so stale ones never match
    task automatic send(input logic sop, input logic eop, input logic hold);
        int n;
        beatIn <= '{valid: 1'b1, startOfPacketMarker: sop, endOfPacketMarker: eop};
        n = 0;
        @(posedge core_clk);
        while (!streamReady && n < 50) begin
            n++;
            @(posedge core_clk);
        end
        if (n >= 50) timedOut <= 1'b1;
        if (!hold) beatIn <= '{valid: 1'b0, startOfPacketMarker: !sop, endOfPacketMarker: !eop};
    endtask : send
endmodule : rxdst_stream_src

// file: bench/testbench.sv
// Self-checking bench for the receive status tracker
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic [0:31] st;
        logic irq;
    } rxdst_note_type;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic descValid = 1'b0;
    rxdst_pkg::rxdst_desc_type descIn = '0;
    logic descReady, descDone, streamReady, channelHalted, irqEvent, srcTimedOut;
    // Bench-side limit flag; the stream model reports its own limit separately
    logic timedOut = 1'b0;
    rxdst_pkg::rxdst_beat_type beatIn;
    logic chainPending = 1'b0;
    logic queuesEmpty = 1'b1;
    logic rxErrorEvent = 1'b0;
    logic irqEn = 1'b0;
    logic channelRestart = 1'b0;
    logic statusWrite = 1'b0;
    logic intrWrite = 1'b0;
    logic [0:31] writeData = '0;
    logic [0:31] rx_channel_status;
    logic rx_error_pending;
    int err_count = 0;
    int n_compared = 0;
    rxdst_note_type notes[$];
    rxdst_note_type note;
    int tLen[5] = '{2, 1, 5, 0, 2};
    int tNb[5] = '{2, 1, 2, 0, 2};
    logic [0:4] tSop = 5'b10100;
    logic [0:4] tEop = 5'b10101;
    logic [0:4] tStop = 5'b00001;
    logic [0:4] tIrq = 5'b11010;
    logic [0:4] tEn = 5'b10111;
    logic [0:31] w;

    always #5 core_clk = ~core_clk;

    rxdst_status_tracker #(.LEN_WIDTH(16)) u_rxdst_status_tracker (
        .core_clk(core_clk), .reset(reset), .descValid(descValid), .descIn(descIn),
        .descReady(descReady), .descDone(descDone), .beatIn(beatIn),
        .streamReady(streamReady), .chainPending(chainPending), .queuesEmpty(queuesEmpty),
        .rxErrorEvent(rxErrorEvent), .descriptor_completion_irq_enable(irqEn),
        .channelRestart(channelRestart), .channelHalted(channelHalted),
        .irqEvent(irqEvent), .statusWrite(statusWrite), .intrWrite(intrWrite),
        .writeData(writeData), .rx_channel_status(rx_channel_status),
        .rx_error_pending(rx_error_pending));

    rxdst_stream_src u_rxdst_stream_src (
        .core_clk(core_clk), .streamReady(streamReady), .beatIn(beatIn),
        .timedOut(srcTimedOut));

    function automatic logic [0:31] mk(input logic chan, chain, eop, sop, done, stop, irq, err);
        logic [0:31] v;
        v = '0;
        v[rxdst_pkg::BIT_CHAN_BUSY] = chan;
        v[rxdst_pkg::BIT_CHAIN_BUSY] = chain;
        v[rxdst_pkg::BIT_EOP] = eop;
        v[rxdst_pkg::BIT_SOP] = sop;
        v[rxdst_pkg::BIT_DONE] = done;
        v[rxdst_pkg::BIT_STOP] = stop;
        v[rxdst_pkg::BIT_IRQ] = irq;
        v[rxdst_pkg::BIT_ERR] = err;
        return v;
    endfunction : mk

    task automatic cmp32(input string what, input logic [0:31] e, input logic [0:31] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask : cmp32

    task automatic cmp1(input string what, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %b, seen %b", what, e, g);
        end
    endtask : cmp1

    task automatic tally_and_finish();
        if (err_count == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : tally_and_finish

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
    endtask : step

    task automatic look();
        @(negedge core_clk);
    endtask : look

    task automatic give_desc(input logic stop, input logic irq, input int len);
        int n;
        descValid <= 1'b1;
        descIn <= '{stopOnEnd: stop, irqOnEnd: irq, length: len[15:0]};
        n = 0;
        @(posedge core_clk);
        while (!descReady && n < 50) begin
            n++;
            @(posedge core_clk);
        end
        if (n >= 50) timedOut <= 1'b1;
        descValid <= 1'b0;
    endtask : give_desc

    // Every completion pulse is matched against the oldest note; stray events are errors
    always @(negedge core_clk) begin
        if (!reset && descDone === 1'b1) begin
            if (notes.size() == 0) cmp1("descDone", 1'b0, descDone);
            else begin
                note = notes.pop_front();
                cmp32("status at completion", note.st, rx_channel_status);
                cmp1("irqEvent", note.irq, irqEvent);
            end
        end else if (!reset) cmp1("irqEvent idle", 1'b0, irqEvent);
    end

    always @(posedge timedOut or posedge srcTimedOut) begin
        err_count++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(32'h26F9_E4A0));
        step(4);
        reset <= 1'b0;
        look();
        cmp32("status after reset", '0, rx_channel_status);
        cmp1("descReady after reset", 1'b1, descReady);
        cmp1("streamReady after reset", 1'b0, streamReady);
        step(1);
        chainPending <= 1'b1;
        step(1);
        look();
        cmp32("status chain pending", mk(1, 1, 0, 0, 0, 0, 0, 0), rx_channel_status);
        step(1);
        chainPending <= 1'b0;
        queuesEmpty <= 1'b0;
        step(1);
        look();
        cmp32("status queues busy", mk(1, 0, 0, 0, 0, 0, 0, 0), rx_channel_status);
        step(1);
        queuesEmpty <= 1'b1;
        w = $urandom();
        statusWrite <= 1'b1;
        writeData <= w;
        step(1);
        statusWrite <= 1'b0;
        look();
        // Debug-only write; normal traffic never writes the status
        cmp32("status debug write", mk(0, 0, w[29], w[28], w[27], w[26], w[25], 0),
              rx_channel_status);
        step(1);
        for (int i = 0; i < 5; i++) begin
            irqEn <= tEn[i];
            notes.push_back('{st: mk(tStop[i], 0, tEop[i], tSop[i], 1, tStop[i], tIrq[i], 0),
                              irq: tIrq[i] & tEn[i]});
            // Stop-on-end only on the descriptor carrying the end of packet
            give_desc(tStop[i], tIrq[i], tLen[i]);
            for (int j = 0; j < tNb[i]; j++) begin
                u_rxdst_stream_src.send(j == 0 && tSop[i], j == tNb[i] - 1 && tEop[i],
                                        j < tNb[i] - 1);
            end
            for (int k = 0; k < 50 && notes.size() > 0; k++) step(1);
            if (notes.size() > 0) begin
                err_count++;
                tally_and_finish();
            end
        end
        look();
        cmp1("channelHalted", 1'b1, channelHalted);
        cmp1("descReady halted", 1'b0, descReady);
        cmp1("streamReady halted", 1'b0, streamReady);
        step(1);
        channelRestart <= 1'b1;
        step(1);
        channelRestart <= 1'b0;
        rxErrorEvent <= 1'b1;
        step(1);
        rxErrorEvent <= 1'b0;
        look();
        cmp1("descReady restart", 1'b1, descReady);
        cmp1("rx_error_pending set", 1'b1, rx_error_pending);
        // Last descriptor carried only the end of packet, so start stays clear
        cmp32("status error", mk(0, 0, 1, 0, 1, 1, 0, 1), rx_channel_status);
        step(1);
        intrWrite <= 1'b1;
        writeData <= '0;
        step(1);
        w = '0;
        w[rxdst_pkg::INTR_BIT_ERR] = 1'b1;
        writeData <= w;
        look();
        cmp1("rx_error_pending zero write", 1'b1, rx_error_pending);
        step(1);
        intrWrite <= 1'b0;
        look();
        cmp1("rx_error_pending ack", 1'b0, rx_error_pending);
        cmp1("status error bit", 1'b0, rx_channel_status[rxdst_pkg::BIT_ERR]);
        step(1);
        // A new error in the acknowledge cycle must survive the acknowledge
        rxErrorEvent <= 1'b1;
        intrWrite <= 1'b1;
        step(1);
        rxErrorEvent <= 1'b0;
        intrWrite <= 1'b0;
        look();
        cmp1("rx_error_pending set over ack", 1'b1, rx_error_pending);
        tally_and_finish();
    end
endmodule : testbench
